// ### shared/dclb_pkg.sv
// constants, offsets, field positions and types of the acquisition card register bank
package dclb_pkg;

    // clock and conversion timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int CONV_TIME_NS = 8500;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam logic [11:0] CONV_LAST = 12'(CONV_CYCLES - 1);

    // read answer latency in cycles after the request edge
    localparam logic [1:0] READ_LAST = 2'h3;

    // sample and fifo shape
    localparam int SAMPLE_W = 16;
    localparam int TAG_W = 5;
    localparam int FIFO_W = SAMPLE_W + TAG_W;
    localparam int FIFO_DEPTH = 1024;
    localparam int FIFO_AW = 10;
    localparam logic [FIFO_AW:0] FIFO_HALF_LVL = 11'(FIFO_DEPTH / 2);
    localparam logic [FIFO_AW:0] FIFO_FULL_LVL = 11'(FIFO_DEPTH);

    // first i/o region offsets
    localparam logic [6:0] OFS_ISO_PORT = 7'h00;
    localparam logic [6:0] OFS_CHANNEL = 7'h02;
    localparam logic [6:0] OFS_GAIN = 7'h04;
    localparam logic [6:0] OFS_TRIG_MODE = 7'h06;
    localparam logic [6:0] OFS_INT_CTRL = 7'h08;
    localparam logic [6:0] OFS_STATUS_KICK = 7'h0a;
    localparam logic [6:0] OFS_IRQ1_CLR = 7'h0c;
    localparam logic [6:0] OFS_IRQ2_CLR = 7'h0e;
    localparam logic [6:0] OFS_TMR_CNT0 = 7'h20;
    localparam logic [6:0] OFS_TMR_CNT1 = 7'h22;
    localparam logic [6:0] OFS_TMR_CNT2 = 7'h24;
    localparam logic [6:0] OFS_TMR_CTRL = 7'h26;
    // second i/o region offset
    localparam logic [6:0] OFS_FIFO_SAMPLE = 7'h40;

    // field positions
    localparam int AUTO_SCAN_BIT = 0;
    localparam int TRIG_SRC_BIT = 1;
    localparam int IRQ1_SRC_BIT = 0;
    localparam int IRQ2_SRC_BIT = 1;
    localparam int FIFO_DIS_BIT = 2;
    localparam int JUMPER_BIT = 3;
    localparam int TAG_LSB = 16;

    // reset values
    localparam logic [15:0] ISO_OUT_RST = 16'h0000;
    localparam logic [4:0] CHANNEL_RST = 5'h00;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [2:0] INT_CTRL_RST = 3'h0;

    // conversion sequencer states
    typedef enum logic [0:0] {
        DCLB_IDLE = 1'b0,
        DCLB_CONV = 1'b1
    } dclb_conv_state_t;

endpackage : dclb_pkg

// ### hdl/dclb_fifo.sv
// sample fifo with its own memory and registered read data
`timescale 1ns/1ps

module dclb_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // synchronous flush, holds the fifo empty
    input wire logic clear,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side, data valid the cycle after the pop
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [AW:0] level
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    // handshakes
    assign in_ready = !clear && (level != (AW+1)'(DEPTH));
    assign out_valid = !clear && (level != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage array, no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (push && !pop) begin
                level <= level + (AW+1)'(1);
            end else if (pop && !push) begin
                level <= level - (AW+1)'(1);
            end
        end
    end

    // registered read data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_data <= '0;
        end else if (pop) begin
            out_data <= mem[rd_ptr];
        end
    end

endmodule : dclb_fifo

// ### hdl/dclb_reg_bank.sv
// local register bank of the acquisition card: bridge i/o decode, converter control, fifo, timer window
`timescale 1ns/1ps

// Overview of operation
// - control registers are 16-bit words at even offsets of the first region.
// - wide read at 0x40 of second region pops one sample with tag.
// - narrow read of the sample port returns only the 16-bit value.
// - five channel bits select the channel, or the last scan channel.
// - channel readback returns the written value, not the scanning channel.
// - two gain bits drive the amplifier gain select directly.
// - status bit 0 low when empty, bit 1 low when half full.
// - status bit 2 low when the fifo is full.
// - status bit 3 low while converting, rises as the result is stored.
// - trigger mode bit 0 switches automatic channel scanning.
// - trigger mode bit 1 set selects the timer pulse as trigger.
// - first interrupt from each conversion end, or from reaching half full.
// - second interrupt comes only from the interval timer.
// - interrupt control bit 2 disables the fifo; 0-1-0 resets it.
// - interrupt control bit 3 reads the input-type jumper, writes ignored.
// - with the timer source off, a write to 0x0A triggers a conversion if idle; read gives fifo status.
// - interrupts are levels held until their clear offset is written.
// - 0x20 to 0x24 reach timer counters, 0x26 takes the control byte.
// - auto-scan steps channel per trigger from 0 to last, then wraps.
// - with timer source off only software writes trigger conversions.
// - fifo holds 1024 entries, results arriving when full are dropped.
// - each conversion is stored within 8.5 microseconds of its trigger.
module dclb_reg_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bridge local i/o bus
    input wire logic lb_sel_main,
    input wire logic lb_sel_fifo,
    input wire logic [6:0] lb_addr,
    input wire logic lb_wr,
    input wire logic lb_rd,
    input wire logic lb_wide,
    input wire logic [15:0] lb_wdata,
    output logic [31:0] lb_rdata,
    output logic lb_rvalid,
    // isolated digital port and input-type jumper
    input wire logic [15:0] iso_in,
    output logic [15:0] iso_out,
    input wire logic input_type_jumper_pin,
    // converter and amplifier
    output logic adc_start,
    output logic [4:0] adc_channel,
    output logic [1:0] gain_code,
    input wire logic adc_done,
    input wire logic [15:0] adc_result,
    // interval timer chip
    output logic [1:0] tmr_addr,
    output logic [7:0] tmr_wdata,
    output logic tmr_wr,
    output logic tmr_rd,
    input wire logic [7:0] tmr_rdata,
    input wire logic tmr_pace,
    input wire logic tmr_irq,
    // level interrupts to the bridge
    output logic irq_first,
    output logic irq_second
);

    localparam int SYNC_W = 44;

    // offset decode used throughout
    function automatic logic reg_hit(input logic [6:0] a, input logic [6:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    function automatic logic timer_hit(input logic [6:0] a);
        timer_hit = reg_hit(a, dclb_pkg::OFS_TMR_CNT0) || reg_hit(a, dclb_pkg::OFS_TMR_CNT1) ||
                    reg_hit(a, dclb_pkg::OFS_TMR_CNT2) || reg_hit(a, dclb_pkg::OFS_TMR_CTRL);
    endfunction : timer_hit

    // input synchroniser stages
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [15:0] iso_in_s;
    logic jumper_s;
    logic done_s;
    logic [15:0] result_s;
    logic [7:0] tmr_rdata_s;
    logic pace_s;
    logic tirq_s;
    logic done_d;
    logic pace_d;
    logic tirq_d;
    logic half_d;

    // software registers
    logic [4:0] channel_setting;
    logic gain_code_high;
    logic gain_code_low;
    logic auto_scan_enable;
    logic trigger_source_select;
    logic first_irq_source_select;
    logic second_irq_source_select;
    logic fifo_disable_bit;

    // bus request tracking
    logic wr_take;
    logic rd_take;
    logic pop_now;
    logic [1:0] rd_cnt;
    logic [6:0] rq_addr;
    logic rq_fifo;
    logic rq_wide;
    logic rq_popped;
    logic [31:0] rd_word;

    // conversion sequencer
    dclb_pkg::dclb_conv_state_t conv_state;
    logic [11:0] conv_cnt;
    logic [4:0] scan_ch;
    logic [4:0] sample_channel_tag;
    logic trigger;
    logic start;
    logic store;
    logic [11:0] busy_run;

    // fifo side signals and active-low flags
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [dclb_pkg::FIFO_W-1:0] fifo_out_data;
    logic [dclb_pkg::FIFO_AW:0] fifo_level;
    logic fifo_empty_n;
    logic fifo_half_n;
    logic fifo_full_n;
    logic adc_busy_n;
    logic first_evt;
    logic second_evt;

    // two-stage capture of every pin input
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {iso_in, input_type_jumper_pin, adc_done, adc_result, tmr_rdata, tmr_pace, tmr_irq};
            sync_b <= sync_a;
        end
    end
    assign {iso_in_s, jumper_s, done_s, result_s, tmr_rdata_s, pace_s, tirq_s} = sync_b;

    // delayed copies for edge detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_d <= 1'b0;
            pace_d <= 1'b0;
            tirq_d <= 1'b0;
            half_d <= 1'b0;
        end else begin
            done_d <= done_s;
            pace_d <= pace_s;
            tirq_d <= tirq_s;
            half_d <= !fifo_half_n;
        end
    end

    // request acceptance
    assign wr_take = lb_wr && lb_sel_main;
    assign rd_take = lb_rd && (lb_sel_main || lb_sel_fifo) && (rd_cnt == 2'h0);
    assign pop_now = rd_take && lb_sel_fifo && reg_hit(lb_addr, dclb_pkg::OFS_FIFO_SAMPLE) && fifo_out_valid;

    // writable control registers, unused bits dropped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            iso_out <= dclb_pkg::ISO_OUT_RST;
            channel_setting <= dclb_pkg::CHANNEL_RST;
            {gain_code_high, gain_code_low} <= dclb_pkg::GAIN_RST;
            {trigger_source_select, auto_scan_enable} <= dclb_pkg::MODE_RST;
            {fifo_disable_bit, second_irq_source_select, first_irq_source_select} <= dclb_pkg::INT_CTRL_RST;
        end else if (wr_take) begin
            if (reg_hit(lb_addr, dclb_pkg::OFS_ISO_PORT)) begin
                iso_out <= lb_wdata;
            end
            if (reg_hit(lb_addr, dclb_pkg::OFS_CHANNEL)) begin
                channel_setting <= lb_wdata[4:0];
            end
            if (reg_hit(lb_addr, dclb_pkg::OFS_GAIN)) begin
                {gain_code_high, gain_code_low} <= lb_wdata[1:0];
            end
            if (reg_hit(lb_addr, dclb_pkg::OFS_TRIG_MODE)) begin
                auto_scan_enable <= lb_wdata[dclb_pkg::AUTO_SCAN_BIT];
                trigger_source_select <= lb_wdata[dclb_pkg::TRIG_SRC_BIT];
            end
            if (reg_hit(lb_addr, dclb_pkg::OFS_INT_CTRL)) begin
                first_irq_source_select <= lb_wdata[dclb_pkg::IRQ1_SRC_BIT];
                second_irq_source_select <= lb_wdata[dclb_pkg::IRQ2_SRC_BIT];
                fifo_disable_bit <= lb_wdata[dclb_pkg::FIFO_DIS_BIT];
            end
        end
    end
    assign gain_code = {gain_code_high, gain_code_low};

    // read sequencing: answer three cycles after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_cnt <= 2'h0;
            rq_addr <= 7'h00;
            rq_fifo <= 1'b0;
            rq_wide <= 1'b0;
            rq_popped <= 1'b0;
        end else if (rd_take) begin
            rd_cnt <= 2'h1;
            rq_addr <= lb_addr;
            rq_fifo <= lb_sel_fifo;
            rq_wide <= lb_wide;
            rq_popped <= pop_now;
        end else if (rd_cnt == dclb_pkg::READ_LAST) begin
            rd_cnt <= 2'h0;
        end else if (rd_cnt != 2'h0) begin
            rd_cnt <= rd_cnt + 2'h1;
        end
    end

    // read data selection
    always_comb begin
        rd_word = 32'h0000_0000;
        if (rq_fifo) begin
            if (reg_hit(rq_addr, dclb_pkg::OFS_FIFO_SAMPLE) && rq_popped) begin
                rd_word[15:0] = fifo_out_data[15:0];
                if (rq_wide) begin
                    rd_word[dclb_pkg::TAG_LSB +: dclb_pkg::TAG_W] = fifo_out_data[20:16];
                end
            end
        end else if (reg_hit(rq_addr, dclb_pkg::OFS_ISO_PORT)) begin
            rd_word[15:0] = iso_in_s;
        end else if (reg_hit(rq_addr, dclb_pkg::OFS_CHANNEL)) begin
            rd_word[4:0] = channel_setting;
        end else if (reg_hit(rq_addr, dclb_pkg::OFS_GAIN)) begin
            rd_word[1:0] = gain_code;
        end else if (reg_hit(rq_addr, dclb_pkg::OFS_TRIG_MODE)) begin
            rd_word[1:0] = {trigger_source_select, auto_scan_enable};
        end else if (reg_hit(rq_addr, dclb_pkg::OFS_INT_CTRL)) begin
            rd_word[3:0] = {jumper_s, fifo_disable_bit, second_irq_source_select, first_irq_source_select};
        end else if (reg_hit(rq_addr, dclb_pkg::OFS_STATUS_KICK)) begin
            rd_word[3:0] = {adc_busy_n, fifo_full_n, fifo_half_n, fifo_empty_n};
        end else if (timer_hit(rq_addr)) begin
            rd_word[7:0] = tmr_rdata_s;
        end
    end

    // registered answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lb_rdata <= 32'h0000_0000;
            lb_rvalid <= 1'b0;
        end else begin
            lb_rvalid <= (rd_cnt == dclb_pkg::READ_LAST);
            if (rd_cnt == dclb_pkg::READ_LAST) begin
                lb_rdata <= rd_word;
            end
        end
    end

    // timer chip window
    assign tmr_rd = (rd_cnt != 2'h0) && !rq_fifo && timer_hit(rq_addr);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmr_addr <= 2'h0;
            tmr_wdata <= 8'h00;
            tmr_wr <= 1'b0;
        end else begin
            tmr_wr <= wr_take && timer_hit(lb_addr);
            if (wr_take && timer_hit(lb_addr)) begin
                tmr_addr <= lb_addr[2:1];
                tmr_wdata <= lb_wdata[7:0];
            end else if (rd_take && lb_sel_main && timer_hit(lb_addr)) begin
                tmr_addr <= lb_addr[2:1];
            end
        end
    end

    // trigger source selection and conversion start
    assign trigger = trigger_source_select ? (pace_s && !pace_d)
                   : (wr_take && reg_hit(lb_addr, dclb_pkg::OFS_STATUS_KICK));
    assign start = trigger && (conv_state == dclb_pkg::DCLB_IDLE);
    assign store = (conv_state == dclb_pkg::DCLB_CONV) &&
                   ((done_s && !done_d) || (conv_cnt == dclb_pkg::CONV_LAST));

    // conversion sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_state <= dclb_pkg::DCLB_IDLE;
            conv_cnt <= 12'h000;
            adc_start <= 1'b0;
            sample_channel_tag <= 5'h00;
        end else begin
            adc_start <= start;
            case (conv_state)
                dclb_pkg::DCLB_IDLE: begin
                    conv_cnt <= 12'h000;
                    if (start) begin
                        conv_state <= dclb_pkg::DCLB_CONV;
                        sample_channel_tag <= adc_channel;
                    end
                end
                dclb_pkg::DCLB_CONV: begin
                    conv_cnt <= conv_cnt + 12'h001;
                    if (store) begin
                        conv_state <= dclb_pkg::DCLB_IDLE;
                    end
                end
                default: begin
                    conv_state <= dclb_pkg::DCLB_IDLE;
                end
            endcase
        end
    end

    // channel selection and auto-scan stepping
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scan_ch <= 5'h00;
            adc_channel <= 5'h00;
        end else begin
            if (!auto_scan_enable) begin
                scan_ch <= 5'h00;
            end else if (start) begin
                scan_ch <= (scan_ch >= channel_setting) ? 5'h00 : scan_ch + 5'h01;
            end
            if (conv_state == dclb_pkg::DCLB_IDLE && !start) begin
                adc_channel <= auto_scan_enable ? scan_ch : channel_setting;
            end
        end
    end

    // sample storage, dropped while the fifo refuses
    dclb_fifo #(
        .WIDTH(dclb_pkg::FIFO_W),
        .DEPTH(dclb_pkg::FIFO_DEPTH),
        .AW(dclb_pkg::FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .clear(fifo_disable_bit),
        .in_valid(store),
        .in_ready(fifo_in_ready),
        .in_data({sample_channel_tag, result_s}),
        .out_valid(fifo_out_valid),
        .out_ready(pop_now),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // active-low status flags
    assign fifo_empty_n = (fifo_level != '0);
    assign fifo_half_n = (fifo_level < dclb_pkg::FIFO_HALF_LVL);
    assign fifo_full_n = (fifo_level != dclb_pkg::FIFO_FULL_LVL);
    assign adc_busy_n = (conv_state == dclb_pkg::DCLB_IDLE);

    // interrupt sources
    assign first_evt = first_irq_source_select ? (!fifo_half_n && !half_d) : store;
    assign second_evt = second_irq_source_select && tirq_s && !tirq_d;

    // held interrupt levels, a new event wins over the clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_first <= 1'b0;
            irq_second <= 1'b0;
        end else begin
            irq_first <= first_evt || (irq_first && !(wr_take && reg_hit(lb_addr, dclb_pkg::OFS_IRQ1_CLR)));
            irq_second <= second_evt || (irq_second && !(wr_take && reg_hit(lb_addr, dclb_pkg::OFS_IRQ2_CLR)));
        end
    end

    // cycles spent converting so far, watched by the time bound check
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_run <= 12'h000;
        end else if (adc_busy_n) begin
            busy_run <= 12'h000;
        end else begin
            busy_run <= busy_run + 12'h001;
        end
    end

    // checks on the bank's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    wide_tag_read_a: assert property (lb_rvalid && rq_fifo && rq_popped && rq_wide |->
        lb_rdata[20:0] == fifo_out_data && lb_rdata[31:21] == 11'h000) else $error("wide sample read mismatch");
    narrow_read_a: assert property (lb_rvalid && !rq_wide |-> lb_rdata[31:16] == 16'h0000)
        else $error("narrow read has upper bits");
    chan_readback_a: assert property (rd_take && lb_sel_main && reg_hit(lb_addr, dclb_pkg::OFS_CHANNEL) && !wr_take
        ##1 !wr_take [*3] |=> lb_rvalid && lb_rdata[4:0] == channel_setting) else $error("channel readback wrong");
    gain_follow_a: assert property (wr_take && reg_hit(lb_addr, dclb_pkg::OFS_GAIN) |=>
        gain_code == $past(lb_wdata[1:0])) else $error("gain select not updated");
    busy_store_a: assert property ($rose(adc_busy_n) |-> $past(store))
        else $error("busy released without store");
    kick_start_a: assert property (wr_take && reg_hit(lb_addr, dclb_pkg::OFS_STATUS_KICK) && !trigger_source_select
        && adc_busy_n |=> adc_start ##1 !adc_start) else $error("software kick gave no single start");
    pace_ignored_a: assert property (!trigger_source_select && !(wr_take && reg_hit(lb_addr, dclb_pkg::OFS_STATUS_KICK))
        |=> !adc_start) else $error("start without software kick");
    irq_hold_a: assert property (irq_first && !(wr_take && reg_hit(lb_addr, dclb_pkg::OFS_IRQ1_CLR)) |=> irq_first)
        else $error("first interrupt dropped without clear");
    conv_bound_a: assert property (!adc_busy_n |-> busy_run <= dclb_pkg::CONV_LAST)
        else $error("conversion exceeded its time");
    full_drop_a: assert property (!fifo_full_n && !pop_now && !fifo_disable_bit |=>
        fifo_level == dclb_pkg::FIFO_FULL_LVL)
        else $error("full fifo accepted data");

    wide_pop_c: cover property (lb_rvalid && rq_fifo && rq_popped && rq_wide);
    scan_wrap_c: cover property (auto_scan_enable && start && scan_ch != 5'h00 ##1 scan_ch == 5'h00);
    fifo_full_c: cover property (!fifo_full_n);
    irq_clear_c: cover property (irq_first ##1 !irq_first);

endmodule : dclb_reg_bank

// ### verif/dclb_adc_model.sv
// converter stand-in: answers each start pulse with a result built from the channel
`timescale 1ns/1ps
module dclb_adc_model (
    // clock
    input wire logic clk,
    // converter pins
    input wire logic adc_start,
    input wire logic [4:0] adc_channel,
    output logic adc_done,
    output logic [15:0] adc_result
);
    int cnt = 0;
    // result settles well before done rises, and wanders again on the same edge that done falls
    always @(posedge clk) begin
        cnt <= adc_start ? 24 : (cnt > 0 ? cnt - 1 : 0);
        adc_done <= (cnt >= 1 && cnt <= 12);
        adc_result <= (cnt == 20) ? {11'h451, adc_channel} : (cnt == 0 ? ~adc_result : adc_result);
    end
    initial adc_done = 1'b0;
    initial adc_result = 16'hbeef;
endmodule : dclb_adc_model

// ### verif/tb_top.sv
// register bank bench: bus tasks, register checks and conversions through the converter stand-in
`timescale 1ns/1ps
module tb_top;
    logic clk, rstn, sel_m, sel_f, wr_s, rd_s, wide, jumper, done, rvalid, start, irq1, tmr_wr, tw_seen;
    logic tmr_rd, tr_seen, pace, tirq, irq2;
    logic [6:0] addr;
    logic [15:0] wdata, iso_out, res;
    logic [31:0] rdata, q;
    logic [4:0] chan;
    logic [1:0] gain, tmr_addr;
    logic [7:0] tmr_wdata;
    int errors = 0, n_tests = 0, cyc = 0, k;
    dclb_reg_bank u_dclb_reg_bank (.clk(clk), .rstn(rstn), .lb_sel_main(sel_m), .lb_sel_fifo(sel_f),
        .lb_addr(addr), .lb_wr(wr_s), .lb_rd(rd_s), .lb_wide(wide), .lb_wdata(wdata), .lb_rdata(rdata),
        .lb_rvalid(rvalid), .iso_in(16'h3c96), .iso_out(iso_out), .input_type_jumper_pin(jumper),
        .adc_start(start), .adc_channel(chan), .gain_code(gain), .adc_done(done), .adc_result(res),
        .tmr_addr(tmr_addr), .tmr_wdata(tmr_wdata), .tmr_wr(tmr_wr), .tmr_rd(tmr_rd), .tmr_rdata(8'h5a),
        .tmr_pace(pace), .tmr_irq(tirq), .irq_first(irq1), .irq_second(irq2));
    dclb_adc_model u_dclb_adc_model (.clk(clk), .adc_start(start), .adc_channel(chan), .adc_done(done),
        .adc_result(res));
    // clock, and sticky flags for the timer write and read strobes
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (tmr_wr === 1'b1) tw_seen <= 1'b1;
    always @(posedge clk) if (tmr_rd === 1'b1) tr_seen <= 1'b1;
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk) #1 {sel_m, wr_s, addr, wdata} = {2'b11, a, d};
        @(posedge clk) #1 {sel_m, wr_s} = 2'b00;
    endtask : wr
    // one read: strobe for one cycle, then wait a bounded time for the answer pulse
    task automatic rd(input logic f, input logic w, input logic [6:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk) #1 {sel_m, sel_f, rd_s, wide, addr} = {!f, f, 1'b1, w, a};
        @(posedge clk) #1 {sel_m, sel_f, rd_s} = 3'b000;
        for (k = 0; k < 8 && rvalid !== 1'b1; k++) @(posedge clk) #1;
        chk("answer pulse", {31'h0, rvalid}, 32'h1);
        chk(nm, rdata, exp);
    endtask : rd
    // pacer pulse, then software kick; wait for the end-of-conversion interrupt and clear it
    task automatic conv();
        pace = 1'b1;
        repeat (3) @(posedge clk);
        #1 pace = 1'b0;
        wr(7'h0a, 16'h1234);
        for (k = 0; k < 3000 && irq1 !== 1'b1; k++) @(posedge clk) #1;
        chk("eoc irq", {31'h0, irq1}, 32'h1);
        wr(7'h0c, 16'hffff);
        chk("irq cleared", {31'h0, irq1}, 32'h0);
    endtask : conv
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    // main sequence
    initial begin
        {rstn, sel_m, sel_f, wr_s, rd_s, wide, jumper, tw_seen, tr_seen, pace, tirq, addr, wdata} = '0;
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        rd(0, 0, 7'h02, 32'h0, "channel at reset");
        rd(0, 0, 7'h0a, 32'he, "status at reset");
        rd(0, 0, 7'h10, 32'h0, "unmapped");
        wr(7'h00, 16'ha5a5);
        chk("iso out", {16'h0, iso_out}, 32'ha5a5);
        rd(0, 0, 7'h00, 32'h3c96, "iso in");
        for (int g = 0; g < 4; g++) begin
            wr(7'h04, 16'hfffc | 16'(g));
            chk("gain pins", {30'h0, gain}, 32'(g));
            rd(0, 0, 7'h04, 32'(g), "gain readback");
        end
        wr(7'h08, 16'hfffb);
        rd(0, 0, 7'h08, 32'h3, "int ctrl differential");
        jumper = 1'b1;
        rd(0, 0, 7'h08, 32'hb, "int ctrl single ended");
        wr(7'h08, 16'h0000);
        wr(7'h02, 16'hffe5);
        rd(0, 0, 7'h02, 32'h5, "channel low bits");
        chk("mux channel", {27'h0, chan}, 32'h5);
        conv();
        rd(0, 0, 7'h0a, 32'hf, "status holding one");
        rd(1, 1, 7'h40, 32'h0005_8a25, "wide sample");
        conv();
        rd(1, 0, 7'h40, 32'h0000_8a25, "narrow sample");
        rd(0, 0, 7'h0a, 32'he, "status drained");
        conv();
        wr(7'h08, 16'h0004);
        wr(7'h08, 16'h0000);
        rd(0, 0, 7'h0a, 32'he, "status after flush");
        wr(7'h02, 16'h0001);
        wr(7'h06, 16'h0001);
        rd(0, 0, 7'h06, 32'h1, "mode readback");
        for (int i = 0; i < 3; i++) begin
            conv();
            rd(1, 1, 7'h40, {11'h0, 5'(i % 2), 11'h451, 5'(i % 2)}, "scan sample");
        end
        rd(0, 0, 7'h02, 32'h1, "channel during scan");
        wr(7'h06, 16'h0002);
        wr(7'h0a, 16'h0000);
        repeat (60) @(posedge clk);
        rd(0, 0, 7'h0a, 32'he, "kick ignored on timer source");
        conv();
        rd(1, 1, 7'h40, 32'h0001_8a21, "pacer sample");
        wr(7'h06, 16'h0000);
        tirq = 1'b1;
        repeat (4) @(posedge clk) #1;
        chk("timer irq masked", {31'h0, irq2}, 32'h0);
        tirq = 1'b0;
        wr(7'h08, 16'h0002);
        tirq = 1'b1;
        repeat (4) @(posedge clk) #1;
        chk("timer irq", {31'h0, irq2}, 32'h1);
        wr(7'h0e, 16'h0000);
        chk("timer irq cleared", {31'h0, irq2}, 32'h0);
        tirq = 1'b0;
        wr(7'h26, 16'h0036);
        @(posedge clk) #1;
        chk("timer write", {21'h0, tw_seen, tmr_addr, tmr_wdata}, 32'h0000_0736);
        rd(0, 0, 7'h22, 32'h5a, "timer counter");
        chk("timer read strobe", {31'h0, tr_seen}, 32'h1);
        print_verdict();
    end
endmodule : tb_top
